/* hw/blad_ctrl.sv */
// Legacy display decode and master-abort handling for the bridge.
`timescale 1ns/1ps
module blad_ctrl (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic cfg_wr_i,
  input wire blad_pkg::blad_ctrl_s cfg_wdata_i,
  output blad_pkg::blad_ctrl_s cfg_rdata_o,
  input wire logic io_enable_i,
  input wire logic mem_enable_i,
  input wire logic serr_enable_i,
  input wire logic pci_mode_i,
  input wire logic fatal_sel_i,
  input wire logic aer_en_i,
  input wire blad_pkg::blad_req_s dn_req_i,
  output blad_pkg::blad_res_s dn_res_o,
  input wire blad_pkg::blad_req_s up_req_i,
  output blad_pkg::blad_res_s up_res_o,
  input wire blad_pkg::blad_ur_s ur_cpl_i,
  output blad_pkg::blad_ur_act_s ur_act_o,
  output logic [31:0] ur_rdata_o,
  input wire logic posted_ma_i,
  output logic posted_drop_o,
  output blad_pkg::blad_err_s err_msg_o
);

  // Control register and its next value.
  blad_pkg::blad_ctrl_s ctrl_ff;
  blad_pkg::blad_ctrl_s nxt_ctrl;
  // Decode answers for both directions.
  blad_pkg::blad_res_s dn_res_ff;
  blad_pkg::blad_res_s nxt_dn_res;
  blad_pkg::blad_res_s up_res_ff;
  blad_pkg::blad_res_s nxt_up_res;
  // Abort handling outputs.
  blad_pkg::blad_ur_act_s ur_act_ff;
  blad_pkg::blad_ur_act_s nxt_ur_act;
  logic [31:0] ur_rdata_ff;
  logic [31:0] nxt_ur_rdata;
  logic posted_drop_ff;
  logic nxt_posted_drop;
  blad_pkg::blad_err_s err_msg_ff;
  blad_pkg::blad_err_s nxt_err_msg;
  // Raw display matches before enables are applied.
  logic dn_disp_match;
  logic up_disp_match;

  // Matches a display address; wide is honoured only with forwarding.
  function automatic logic disp_match(
    input blad_pkg::blad_req_s req,
    input blad_pkg::blad_ctrl_s ctl
  );
    logic lo_ok;
    logic wide;
    lo_ok = ((req.addr[9:0] >= blad_pkg::DISP_IO_A_LO) &&
             (req.addr[9:0] <= blad_pkg::DISP_IO_A_HI)) ||
            ((req.addr[9:0] >= blad_pkg::DISP_IO_B_LO) &&
             (req.addr[9:0] <= blad_pkg::DISP_IO_B_HI));
    wide = ctl.display_wide_io_decode && ctl.display_fwd_en;
    if (req.is_io) begin
      // Only the first 64 KB of I/O space; alias bits matter if wide.
      disp_match = lo_ok &&
                   (req.addr[31:16] == blad_pkg::DISP_IO_TOP) &&
                   (!wide ||
                    (req.addr[15:10] == blad_pkg::DISP_IO_ALIAS));
    end else begin
      // Memory decode covers the fixed display frame buffer.
      disp_match = (req.addr >= blad_pkg::DISP_MEM_LO) &&
                   (req.addr <= blad_pkg::DISP_MEM_HI);
    end
  endfunction

  // Control bits take a software write and read back unchanged.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (cfg_wr_i) begin
      nxt_ctrl = cfg_wdata_i;
    end
  end

  // Control register; reset clears every bit.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_ff.abort_reporting_mode <= blad_pkg::CTRL_RST_ABORT;
      ctrl_ff.display_wide_io_decode <= blad_pkg::CTRL_RST_WIDE;
      ctrl_ff.display_fwd_en <= blad_pkg::CTRL_RST_FWD;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Raw matches on both sides share the same decode.
  assign dn_disp_match = disp_match(dn_req_i, ctrl_ff);
  assign up_disp_match = disp_match(up_req_i, ctrl_ff);

  // Downstream and upstream decode answers.
  always_comb begin
    nxt_dn_res = '0;
    nxt_up_res = '0;
    nxt_dn_res.valid = dn_req_i.valid;
    nxt_up_res.valid = up_req_i.valid;
    if (ctrl_ff.display_fwd_en) begin
      // Claim display addresses regardless of windows and ISA mode.
      nxt_dn_res.display = dn_req_i.valid && dn_disp_match &&
                           (dn_req_i.is_io ? io_enable_i
                                           : mem_enable_i);
      nxt_up_res.display = up_req_i.valid && up_disp_match;
    end
    // Without display forwarding only the windows decide.
    nxt_dn_res.forward = dn_req_i.valid &&
                         (nxt_dn_res.display || dn_req_i.win_hit);
    // Display addresses from the secondary side are held back.
    nxt_up_res.forward = up_req_i.valid && up_req_i.win_hit &&
                         !nxt_up_res.display;
  end

  // Decode answer registers.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dn_res_ff <= '0;
      up_res_ff <= '0;
    end else begin
      dn_res_ff <= nxt_dn_res;
      up_res_ff <= nxt_up_res;
    end
  end

  // Unsupported Request and posted master-abort handling.
  always_comb begin
    nxt_ur_act = '0;
    nxt_ur_rdata = 32'h0000_0000;
    nxt_posted_drop = 1'b0;
    nxt_err_msg = '0;
    nxt_ur_act.valid = ur_cpl_i.valid;
    if (ur_cpl_i.valid && pci_mode_i) begin
      if (ctrl_ff.abort_reporting_mode) begin
        // Reporting: the PCI requester sees Target-Abort.
        nxt_ur_act.target_abort = 1'b1;
      end else begin
        // Quiet: reads get all ones and I/O writes just finish.
        nxt_ur_act.all_ones = ur_cpl_i.is_read;
        nxt_ur_act.complete_ok = ur_cpl_i.is_iowr;
        if (ur_cpl_i.is_read) begin
          nxt_ur_rdata = blad_pkg::UR_READ_DATA;
        end
      end
    end
    if (posted_ma_i) begin
      // The posted data is discarded in either mode.
      nxt_posted_drop = 1'b1;
      // Reporting mode raises a message if SERR# is enabled.
      nxt_err_msg.valid = ctrl_ff.abort_reporting_mode &&
                          serr_enable_i;
      nxt_err_msg.fatal = nxt_err_msg.valid && aer_en_i && fatal_sel_i;
    end
  end

  // Abort handling registers.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ur_act_ff <= '0;
      ur_rdata_ff <= 32'h0000_0000;
      posted_drop_ff <= 1'b0;
      err_msg_ff <= '0;
    end else begin
      ur_act_ff <= nxt_ur_act;
      ur_rdata_ff <= nxt_ur_rdata;
      posted_drop_ff <= nxt_posted_drop;
      err_msg_ff <= nxt_err_msg;
    end
  end

  // Every output comes straight from a register.
  assign cfg_rdata_o = ctrl_ff;
  assign dn_res_o = dn_res_ff;
  assign up_res_o = up_res_ff;
  assign ur_act_o = ur_act_ff;
  assign ur_rdata_o = ur_rdata_ff;
  assign posted_drop_o = posted_drop_ff;
  assign err_msg_o = err_msg_ff;

  // Quiet mode read completion returns all ones.
  chk_ur_all_ones: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    ur_cpl_i.valid && ur_cpl_i.is_read && pci_mode_i &&
    !ctrl_ff.abort_reporting_mode |=> ur_act_o.all_ones &&
    (ur_rdata_o == 32'hFFFF_FFFF) && !ur_act_o.target_abort)
    else $error("UR read did not return all ones");

  // Quiet mode I/O write completion finishes normally.
  chk_ur_iowr_ok: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    ur_cpl_i.valid && ur_cpl_i.is_iowr && pci_mode_i &&
    !ctrl_ff.abort_reporting_mode |=>
    ur_act_o.complete_ok && !ur_act_o.target_abort)
    else $error("UR I/O write not completed normally");

  // Outside PCI mode the completion is marked valid but carries no action bit.
  chk_ur_not_pci: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    ur_cpl_i.valid && !pci_mode_i |=> ur_act_o.valid &&
    !ur_act_o.all_ones && !ur_act_o.complete_ok &&
    !ur_act_o.target_abort)
    else $error("UR action taken outside PCI mode");

  // Posted master-abort in quiet mode is dropped with no message.
  chk_posted_quiet: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    posted_ma_i && !ctrl_ff.abort_reporting_mode |=>
    posted_drop_o && !err_msg_o.valid)
    else $error("Quiet posted master-abort not dropped silently");

  // Reporting mode turns UR into Target-Abort.
  chk_ur_tabort: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    ur_cpl_i.valid && pci_mode_i && ctrl_ff.abort_reporting_mode |=>
    ur_act_o.target_abort && !ur_act_o.all_ones)
    else $error("UR not reported as Target-Abort");

  // Message follows SERR# enable and the severity selection.
  chk_posted_msg: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    posted_ma_i && ctrl_ff.abort_reporting_mode |=>
    (err_msg_o.valid == $past(serr_enable_i)) &&
    (err_msg_o.fatal == $past(serr_enable_i && aer_en_i && fatal_sel_i)))
    else $error("Posted master-abort message wrong");

  // A message only ever follows a reported, enabled master-abort.
  chk_msg_needs_serr: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    err_msg_o.valid |->
    $past(posted_ma_i && serr_enable_i && ctrl_ff.abort_reporting_mode))
    else $error("Error message sent without its cause");

  // Fatal severity needs error reporting support and the selection.
  chk_err_fatal_sel: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    err_msg_o.fatal |-> err_msg_o.valid && $past(aer_en_i && fatal_sel_i))
    else $error("Fatal message without severity selection");

  // Wide decode rejects a nonzero alias, only with forwarding on.
  chk_wide_alias: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    dn_req_i.valid && dn_req_i.is_io && io_enable_i &&
    ctrl_ff.display_fwd_en && (dn_req_i.addr[31:16] == 16'h0000) &&
    (dn_req_i.addr[9:0] == 10'h3C0) && (dn_req_i.addr[15:10] != 6'h00)
    |=> dn_res_o.display == !$past(ctrl_ff.display_wide_io_decode))
    else $error("Display I/O alias decode wrong");

  // Forwarding off: the display range follows only the window.
  chk_fwd_off: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    dn_req_i.valid && !ctrl_ff.display_fwd_en |=>
    !dn_res_o.display && (dn_res_o.forward == $past(dn_req_i.win_hit)))
    else $error("Display decode active with forwarding off");

  // Display memory edges are claimed when memory is enabled.
  chk_mem_range: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    dn_req_i.valid && !dn_req_i.is_io && ctrl_ff.display_fwd_en &&
    ((dn_req_i.addr == 32'h000A_0000) || (dn_req_i.addr == 32'h000B_FFFF))
    |=> dn_res_o.display == $past(mem_enable_i))
    else $error("Display memory range decode wrong");

  // A downstream display claim needs the matching space enable.
  chk_dn_enable_gate: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    dn_res_o.display |->
    $past(dn_req_i.is_io ? io_enable_i : mem_enable_i))
    else $error("Display claimed with its space disabled");

  // Answers come one cycle later; a display claim always forwards.
  chk_dn_forward: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    dn_req_i.valid |=> dn_res_o.valid &&
    (dn_res_o.forward ==
     (dn_res_o.display || $past(dn_req_i.win_hit))))
    else $error("Downstream forward decision wrong");

  // A display address never travels upstream while forwarding is on.
  chk_up_block: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    up_res_o.display |-> !up_res_o.forward &&
    $past(ctrl_ff.display_fwd_en))
    else $error("Display address forwarded upstream");

  // Upstream traffic follows the window unless it is a display address.
  chk_up_window: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    up_req_i.valid |=> up_res_o.valid &&
    (up_res_o.forward ==
     ($past(up_req_i.win_hit) && !up_res_o.display)))
    else $error("Upstream forward decision wrong");

  // Display I/O outside the first 64 KB is never claimed.
  chk_io_top: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    dn_req_i.valid && dn_req_i.is_io &&
    (dn_req_i.addr[31:16] != 16'h0000) |=> !dn_res_o.display)
    else $error("Display I/O claimed above 64 KB");

  // Control bits come up cleared after reset.
  chk_ctrl_reset: assert property (
    @(posedge mclk_i)
    srst_i |=> (cfg_rdata_o == '0))
    else $error("Control bits not cleared by reset");

  // A configuration write shows up on the read-back one cycle later.
  chk_ctrl_write: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    cfg_wr_i |=> cfg_rdata_o == $past(cfg_wdata_i))
    else $error("Control write not stored");

  // Without a write the control bits keep their value.
  chk_ctrl_hold: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    !cfg_wr_i |=> $stable(cfg_rdata_o))
    else $error("Control bits changed without a write");

endmodule // blad_ctrl

/* hw/blad_pkg.sv */
// Package of constants and carrier types for the legacy decode/abort block.
package blad_pkg;

  // Display memory range, inclusive bounds.
  localparam logic [31:0] DISP_MEM_LO = 32'h000A_0000;
  localparam logic [31:0] DISP_MEM_HI = 32'h000B_FFFF;

  // Display I/O ranges on the low ten address bits, inclusive.
  localparam logic [9:0] DISP_IO_A_LO = 10'h3B0;
  localparam logic [9:0] DISP_IO_A_HI = 10'h3BB;
  localparam logic [9:0] DISP_IO_B_LO = 10'h3C0;
  localparam logic [9:0] DISP_IO_B_HI = 10'h3DF;

  // Upper I/O bits that must be zero for the display I/O decode.
  localparam logic [15:0] DISP_IO_TOP = 16'h0000;
  // Alias bits compared only under wide decode.
  localparam logic [5:0] DISP_IO_ALIAS = 6'h00;

  // Read data returned for an unreported Unsupported Request.
  localparam logic [31:0] UR_READ_DATA = 32'hFFFF_FFFF;

  // Reset values of the three control bits.
  localparam logic CTRL_RST_ABORT = 1'h0;
  localparam logic CTRL_RST_WIDE = 1'h0;
  localparam logic CTRL_RST_FWD = 1'h0;

  // Software-visible control bits.
  typedef struct packed {
    logic abort_reporting_mode;   // Report master-aborts when set.
    logic display_wide_io_decode; // 16-bit display I/O decode.
    logic display_fwd_en;         // Legacy display forwarding.
  } blad_ctrl_s;

  // One address decode request from either side.
  typedef struct packed {
    logic        valid;  // Request present this cycle.
    logic [31:0] addr;   // Request address.
    logic        is_io;  // I/O space when set, memory when clear.
    logic        win_hit; // Hit in base/limit windows (with ISA rule).
  } blad_req_s;

  // Registered decode answer.
  typedef struct packed {
    logic valid;   // Answer present.
    logic forward; // Pass the request across the bridge.
    logic display; // Request matched the display decode.
  } blad_res_s;

  // Unsupported Request completion received from PCIe.
  typedef struct packed {
    logic valid;   // Completion arrives this cycle.
    logic is_read; // Completion for a non-posted read.
    logic is_iowr; // Completion for a non-posted I/O write.
  } blad_ur_s;

  // Action to take on the PCI transaction for that completion.
  typedef struct packed {
    logic valid;        // Action present.
    logic all_ones;     // Return read data of all ones.
    logic complete_ok;  // Finish the I/O write normally.
    logic target_abort; // End the PCI transaction with Target-Abort.
  } blad_ur_act_s;

  // Error message request towards PCIe.
  typedef struct packed {
    logic valid; // Send a message.
    logic fatal; // ERR_FATAL when set, ERR_NONFATAL when clear.
  } blad_err_s;

endpackage

/* verif/blad_far_agent.sv */
// Far-side request agent that presents address decode requests.
`timescale 1ns/1ps
module blad_far_agent (
  input wire logic mclk_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic is_io_i,
  input wire logic win_i,
  output blad_pkg::blad_req_s req_o
);
  // Idle address pattern, so no stale address lingers between requests.
  logic [31:0] junk_ff = 32'h5A5A_C3C3;

  // The pattern changes every cycle while the agent is idle.
  always_ff @(posedge mclk_i) begin
    junk_ff <= junk_ff * 32'h0001_0DCD + 32'h0000_3C6F;
  end

  // A request shows its fields; an idle agent shows scrambled lines.
  assign req_o = req_i ? {1'b1, addr_i, is_io_i, win_i}
                       : {1'b0, junk_ff, ~is_io_i, ~win_i};
endmodule // blad_far_agent

/* verif/bridge_legacy_decode_abort_ctrl_tb.sv */
// Self-checking bench for the legacy decode and abort control block.
`timescale 1ns/1ps
module bridge_legacy_decode_abort_ctrl_tb;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr = 1'b0, ioe = 1'b0, meme = 1'b0, serr = 1'b0, pcim = 1'b0;
  logic fsel = 1'b0, aer = 1'b0, pma = 1'b0;
  logic dv = 1'b0, dio = 1'b0, dw = 1'b0, uv = 1'b0, uio = 1'b0, uw = 1'b0;
  logic [31:0] da = 32'h0, ua = 32'h0;
  blad_pkg::blad_ctrl_s wd = '0, ct = '0, rd;
  blad_pkg::blad_req_s dn_req, up_req;
  blad_pkg::blad_res_s dn_res, up_res;
  blad_pkg::blad_ur_s ur = '0;
  blad_pkg::blad_ur_act_s ua_o;
  blad_pkg::blad_err_s err;
  logic [31:0] urd;
  logic drop;
  logic [3:0] e_ur = 4'h0;
  logic [2:0] e_dn = 3'h0, e_up = 3'h0, e_cfg = 3'h0;
  logic [1:0] e_err = 2'h0;
  logic [31:0] e_rd = 32'h0;
  logic e_drop = 1'b0, md;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  // Addresses on, inside and just beyond the display range edges.
  logic [31:0] tbl [12] = '{32'h000A_0000, 32'h000B_FFFF, 32'h0009_FFFF,
    32'h000C_0000, 32'h000A_C123, 32'h0000_03B0, 32'h0000_03BB,
    32'h0000_03BC, 32'h0000_03AF, 32'h0000_03C0, 32'h0000_03DF,
    32'h0000_03E0};

  // The clock toggles every half period of 5 ns.
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  blad_ctrl dut (.mclk_i(mclk_i), .srst_i(srst_i), .cfg_wr_i(wr),
    .cfg_wdata_i(wd), .cfg_rdata_o(rd), .io_enable_i(ioe),
    .mem_enable_i(meme), .serr_enable_i(serr), .pci_mode_i(pcim),
    .fatal_sel_i(fsel), .aer_en_i(aer), .dn_req_i(dn_req),
    .dn_res_o(dn_res), .up_req_i(up_req), .up_res_o(up_res),
    .ur_cpl_i(ur), .ur_act_o(ua_o), .ur_rdata_o(urd),
    .posted_ma_i(pma), .posted_drop_o(drop), .err_msg_o(err));
  blad_far_agent dn_agt (.mclk_i(mclk_i), .req_i(dv), .addr_i(da),
    .is_io_i(dio), .win_i(dw), .req_o(dn_req));
  blad_far_agent up_agt (.mclk_i(mclk_i), .req_i(uv), .addr_i(ua),
    .is_io_i(uio), .win_i(uw), .req_o(up_req));

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Picks a boundary address, sometimes with alias or high bits set.
  function automatic logic [31:0] pick();
    logic [31:0] a;
    a = tbl[$urandom % 12];
    if (a[31:10] == 22'h0 && $urandom % 2 == 0) a[15:10] = 6'($urandom);
    if ($urandom % 10 == 0) a[31:16] = 16'($urandom);
    return a;
  endfunction

  // Reference decode answer for one request and direction.
  function automatic logic [2:0] dec(input blad_pkg::blad_req_s r,
                                     input bit dn);
    logic m, d;
    if (r.is_io) m = r.addr[31:16] == 16'h0 &&
      ((r.addr[9:0] >= 10'h3B0 && r.addr[9:0] <= 10'h3BB) ||
       (r.addr[9:0] >= 10'h3C0 && r.addr[9:0] <= 10'h3DF)) &&
      !(ct.display_wide_io_decode && ct.display_fwd_en &&
        r.addr[15:10] != 6'h0);
    else m = r.addr >= 32'h000A_0000 && r.addr <= 32'h000B_FFFF;
    d = ct.display_fwd_en && m && (!dn || (r.is_io ? ioe : meme));
    if (!r.valid) return 3'h0;
    return {1'b1, dn ? (d || r.win_hit) : (r.win_hit && !d), d};
  endfunction

  // Drives random inputs at a rising edge, compares at the falling edge.
  task automatic run(input int n, input int rst_n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      srst_i <= i < rst_n;
      wr <= i >= rst_n && $urandom % 6 == 0;
      wd <= 3'($urandom);
      {ioe, meme, serr, pcim, fsel, aer} <= 6'($urandom);
      dv <= i >= rst_n && 1'($urandom);
      uv <= i >= rst_n && 1'($urandom);
      da <= pick();
      ua <= pick();
      {dio, dw, uio, uw} <= {1'($urandom), $urandom % 4 == 0,
                             1'($urandom), $urandom % 4 == 0};
      ur <= {i >= rst_n && 1'($urandom), 2'($urandom % 2 + 1)};
      pma <= i >= rst_n && 1'($urandom);
      @(negedge mclk_i);
      check(32'(rd), 32'(e_cfg));
      check(32'(dn_res), 32'(e_dn));
      check(32'(up_res), 32'(e_up));
      check(32'(ua_o), 32'(e_ur));
      check(urd, e_rd);
      check(32'({drop, err}), 32'({e_drop, e_err}));
      md = ct.abort_reporting_mode;
      e_dn = srst_i ? 3'h0 : dec(dn_req, 1'b1);
      e_up = srst_i ? 3'h0 : dec(up_req, 1'b0);
      e_ur = (!ur.valid || srst_i) ? 4'h0 : pcim ?
        {1'b1, !md && ur.is_read, !md && ur.is_iowr, md} : 4'h8;
      e_rd = e_ur[2] ? 32'hFFFF_FFFF : 32'h0;
      e_drop = pma && !srst_i;
      e_err = {e_drop && md && serr, e_drop && md && serr && aer && fsel};
      if (srst_i) ct = '0;
      else if (wr) ct = wd;
      e_cfg = ct;
    end
  endtask

  // Cuts a hung run short.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("ERROR at %0t: run did not finish", $time);
      final_report();
    end
  end

  // Main sequence: reset, random traffic, reset in mid-run, more traffic.
  initial begin
    void'($urandom(32'h011F1F0C));
    run(2000, 10);
    $display("test reset and random traffic done");
    run(1000, 3);
    $display("test mid-run reset and traffic done");
    final_report();
  end
endmodule // bridge_legacy_decode_abort_ctrl_tb
